// ==== logic/failure_supervisor.sv ====
// Notes on behaviour
// - self-test sequence runs once at start, then cyclically in normal run
// - each failure is sorted into major or minor class
// - a failing major test enters fail-safe on the next clock
// - minor failure gives degraded mode; protection and outputs stay normal
// - minor failure shown on display and readable in status register
// - fail-safe forces every relay drive to idle, overriding all
// - fail-safe inhibits all protection functions
// - watchdog idle while fail-safe, active otherwise
// - fail-safe lights red indicator and shows a diagnostic code, except zero code in lockout after fifth transient
// - after a major failure a restart reruns the complete test sequence
// - failure still present at restart locks fail-safe until power cycle
// - restart pass resumes protection; fail-safe time lies in 5 to 7 s
// - every transient failure increments the transient counter
// - fifth transient failure locks fail-safe even when its restart passes
// - transient counter cleared only by power-on reset
// - cpu, ram, program sum, relay driver, wiring tested at start and run
// - supply, current, voltage in run only; parameter sum at start only
// - interface, analog output, temperature module presence are minor tests
// - enabled supervision functions raise display alarm and status item
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module failure_supervisor #(
  parameter int unsigned FS_HOLD = supervisor_pkg::FS_HOLD_CYC,
  parameter int unsigned CYCLE = supervisor_pkg::CYCLE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // self-test units
  output logic test_start,
  output logic test_init_phase,
  input wire logic test_done,
  input wire supervisor_pkg::test_result_t test_result,
  // supervision functions and relay path
  input wire logic [supervisor_pkg::N_SUPV-1:0] supv_alarm_in,
  input wire logic [supervisor_pkg::N_RELAY-1:0] relay_request,
  output logic [supervisor_pkg::N_RELAY-1:0] relay_drive,
  output logic protection_enable,
  output logic watchdog_ok,
  output supervisor_pkg::display_t display
);
  import supervisor_pkg::*;

  // ************************************************************
  // helpers
  // ************************************************************
  // diagnostic code: one plus lowest failing major test, zero if none
  function automatic logic [7:0] first_fail(
    input logic [N_MAJOR-1:0] f
  );
    logic [7:0] code;
    code = 8'h00;
    for (int i = N_MAJOR - 1; i >= 0; i--) begin
      if (f[i]) begin
        code = 8'(i + 1);
      end
    end
    return code;
  endfunction

  function automatic logic [N_MAJOR-1:0] phase_mask(input logic init);
    return init ? INIT_MASK : OPER_MASK;
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  sup_state_t state_r;
  sup_state_t state_nxt;
  logic [2:0] transient_cnt_r;
  logic test_busy_r;
  logic test_start_r;
  logic degraded_r;
  logic [N_MINOR-1:0] minor_seen_r;
  logic [N_MAJOR-1:0] major_seen_r;
  logic [7:0] diag_r;
  logic [N_SUPV-1:0] supv_en_r;
  logic [N_SUPV-1:0] supv_alarm_r;
  logic [N_RELAY-1:0] relay_drive_r;
  logic protect_r;
  logic watchdog_r;
  logic red_led_r;
  logic failsafe;
  logic init_phase;
  logic [N_MAJOR-1:0] major_now;
  logic major_hit;
  logic cycle_load;
  logic cycle_due;
  logic hold_load;
  logic hold_done;
  logic transient_pass;

  assign failsafe = state_r == ST_FAILSAFE || state_r == ST_RESTART_TEST ||
                    state_r == ST_LOCKOUT;
  // a restart reruns the full power-up sequence
  assign init_phase = state_r == ST_INIT_TEST ||
                      state_r == ST_RESTART_TEST;
  assign major_now = test_result.major_fail &
                     phase_mask(init_phase);
  assign major_hit = test_done && test_busy_r && major_now != '0;
  assign transient_pass = state_r == ST_RESTART_TEST && test_done &&
                          test_busy_r && major_now == '0;

  // ************************************************************
  // timers
  // ************************************************************
  assign cycle_load = (state_r == ST_INIT_TEST || state_r == ST_RUN) &&
                      test_done && test_busy_r && !major_hit;
  assign hold_load = state_r != ST_FAILSAFE && state_nxt == ST_FAILSAFE;

  down_timer u_cycle_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(cycle_load),
    .count_in(TMR_W'(CYCLE)),
    .expired(cycle_due)
  );

  // hold plus restart tests keep the total within the 5 to 7 s window
  down_timer u_hold_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(hold_load),
    .count_in(TMR_W'(FS_HOLD)),
    .expired(hold_done)
  );

  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_INIT_TEST: begin
        if (major_hit) begin
          state_nxt = ST_FAILSAFE;
        end else if (test_done && test_busy_r) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (major_hit) begin
          state_nxt = ST_FAILSAFE;
        end
      end
      ST_FAILSAFE: begin
        if (hold_done) begin
          state_nxt = ST_RESTART_TEST;
        end
      end
      ST_RESTART_TEST: begin
        if (major_hit) begin
          state_nxt = ST_LOCKOUT;
        end else if (transient_pass) begin
          if (transient_cnt_r + 3'h1 >= TRANSIENT_LIMIT) begin
            state_nxt = ST_LOCKOUT;
          end else begin
            state_nxt = ST_RUN;
          end
        end
      end
      ST_LOCKOUT: begin
        state_nxt = ST_LOCKOUT;
      end
      default: begin
        state_nxt = ST_LOCKOUT;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_INIT_TEST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // only power-on reset clears the count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      transient_cnt_r <= 3'h0;
    end else if (transient_pass && transient_cnt_r != 3'h7) begin
      transient_cnt_r <= transient_cnt_r + 3'h1;
    end
  end

  // test launch: at init, at restart, then each cycle period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_start_r <= 1'b0;
      test_busy_r <= 1'b0;
    end else begin
      test_start_r <= 1'b0;
      if (test_done && test_busy_r) begin
        test_busy_r <= 1'b0;
      end else if (!test_busy_r && !test_start_r &&
                   (state_r == ST_INIT_TEST ||
                    state_r == ST_RESTART_TEST ||
                    (state_r == ST_RUN && cycle_due))) begin
        test_start_r <= 1'b1;
        test_busy_r <= 1'b1;
      end
    end
  end

  assign test_start = test_start_r;
  assign test_init_phase = init_phase;

  // ************************************************************
  // failure records
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      degraded_r <= 1'b0;
      minor_seen_r <= '0;
    end else if (test_done && test_busy_r &&
                 test_result.minor_fail != '0) begin
      degraded_r <= 1'b1;
      minor_seen_r <= minor_seen_r | test_result.minor_fail;
    end else if (state_r == ST_FAILSAFE && hold_done) begin
      degraded_r <= 1'b0;
      minor_seen_r <= '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      major_seen_r <= '0;
      diag_r <= 8'h00;
    end else if (major_hit) begin
      major_seen_r <= major_now;
      diag_r <= first_fail(major_now);
    end else if (transient_pass) begin
      diag_r <= 8'h00;
    end
  end

  // supervision alarms follow their sources while enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      supv_alarm_r <= '0;
    end else begin
      supv_alarm_r <= supv_alarm_in & supv_en_r;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      relay_drive_r <= '0;
      protect_r <= 1'b0;
      watchdog_r <= 1'b0;
      red_led_r <= 1'b0;
    end else begin
      // next-state terms save a cycle on the way in
      relay_drive_r <= (failsafe || major_hit) ? '0 :
                       relay_request;
      protect_r <= !(failsafe || major_hit);
      watchdog_r <= !(failsafe || major_hit);
      red_led_r <= failsafe || major_hit;
    end
  end

  assign relay_drive = relay_drive_r;
  assign protection_enable = protect_r;
  assign watchdog_ok = watchdog_r;
  assign display.red_led = red_led_r;
  assign display.minor_flag = degraded_r;
  assign display.supv_alarm = supv_alarm_r;
  assign display.diag_code = diag_r;

  // ************************************************************
  // axi4-lite write
  // ************************************************************
  logic aw_have_r;
  logic w_have_r;
  logic [3:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;

  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready = !w_have_r && !bvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (aw_have_r && w_have_r && !bvalid_r) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= (aw_addr_r == ADDR_CTRL || aw_addr_r == ADDR_STATUS ||
                    aw_addr_r == ADDR_MINOR || aw_addr_r == ADDR_DIAG) ?
                   RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // control is the only writable register; others ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      supv_en_r <= CTRL_RESET;
    end else if (aw_have_r && w_have_r && !bvalid_r &&
                 aw_addr_r == ADDR_CTRL && w_strb_r[0]) begin
      supv_en_r <= w_data_r[N_SUPV-1:0];
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // ************************************************************
  // axi4-lite read
  // ************************************************************
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  assign s_axi_arready = !rvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r <= RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_CTRL: rdata_r <= {29'h0, supv_en_r};
        ADDR_STATUS: begin
          rdata_r <= {21'h0, transient_cnt_r, degraded_r,
                      state_r == ST_LOCKOUT, failsafe,
                      state_r};
        end
        ADDR_MINOR: begin
          rdata_r <= {16'h0, major_seen_r,
                      supv_alarm_r, minor_seen_r};
        end
        ADDR_DIAG: rdata_r <= {24'h0, diag_r};
        default: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule

// ==== logic/supervisor_pkg.sv ====
package supervisor_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned FS_HOLD_MS = 5500;
  localparam int unsigned CYCLE_MS = 100;
  localparam int unsigned FS_HOLD_CYC = FS_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned CYCLE_CYC = CYCLE_MS * (CLK_HZ / 1000);
  localparam int unsigned TMR_W = 28;
  localparam logic [2:0] TRANSIENT_LIMIT = 3'h5;

  // ************************************************************
  // major test positions
  // ************************************************************
  localparam int MJ_SUPPLY = 0;
  localparam int MJ_CPU = 1;
  localparam int MJ_RAM = 2;
  localparam int MJ_PROG = 3;
  localparam int MJ_PARAM = 4;
  localparam int MJ_CURRENT = 5;
  localparam int MJ_VOLTAGE = 6;
  localparam int MJ_RELAY = 7;
  localparam int MJ_WIRING_A = 8;
  localparam int MJ_WIRING_B = 9;
  localparam int N_MAJOR = 10;
  localparam int N_MINOR = 3;
  localparam int N_SUPV = 3;
  localparam int N_RELAY = 8;

  // tests that run at initialization / during operation
  localparam logic [N_MAJOR-1:0] INIT_MASK = 10'h39e;
  localparam logic [N_MAJOR-1:0] OPER_MASK = 10'h3ef;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_MINOR = 4'h8;
  localparam logic [3:0] ADDR_DIAG = 4'hc;
  localparam logic [N_SUPV-1:0] CTRL_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // types
  // ************************************************************
  typedef struct packed {
    logic [N_MAJOR-1:0] major_fail;
    logic [N_MINOR-1:0] minor_fail;
  } test_result_t;

  typedef struct packed {
    logic red_led;
    logic minor_flag;
    logic [N_SUPV-1:0] supv_alarm;
    logic [7:0] diag_code;
  } display_t;

  typedef enum logic [4:0] {
    ST_INIT_TEST = 5'h01,
    ST_RUN = 5'h02,
    ST_FAILSAFE = 5'h04,
    ST_RESTART_TEST = 5'h08,
    ST_LOCKOUT = 5'h10
  } sup_state_t;

endpackage

// ==== logic/down_timer.sv ====
`timescale 1ns/1ps
module down_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic [supervisor_pkg::TMR_W-1:0] count_in,
  output logic expired
);
  import supervisor_pkg::*;

  logic [TMR_W-1:0] cnt_r;
  logic run_r;

  // the load value is the number of cycles until expired rises
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else if (load) begin
      cnt_r <= count_in;
      run_r <= 1'b1;
    end else if (run_r && cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign expired = run_r && !load && cnt_r == '0;
endmodule

// ==== verif/failure_supervisor_properties.sv ====
`timescale 1ns/1ps
module failure_supervisor_properties #(
  parameter int unsigned FS_HOLD = 50,
  parameter int unsigned CYCLE = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic test_start,
  input wire logic test_init_phase,
  input wire logic test_done,
  input wire supervisor_pkg::test_result_t test_result,
  input wire logic [supervisor_pkg::N_RELAY-1:0] relay_request,
  input wire logic [supervisor_pkg::N_RELAY-1:0] relay_drive,
  input wire logic protection_enable,
  input wire logic watchdog_ok,
  input wire supervisor_pkg::display_t display
);
  import supervisor_pkg::*;
  localparam int CYC_MAX = CYCLE + 8;
  localparam int HOLD_LO = FS_HOLD - 2;
  localparam int HOLD_HI = FS_HOLD + 8;
  logic busy_r;
  logic [31:0] fs_cnt_r;
  logic mj_fail;
  logic [N_MAJOR-1:0] mask;
  // ******
  // pass tracking
  // ******
  assign mask = test_init_phase ? INIT_MASK : OPER_MASK;
  assign mj_fail = test_done && busy_r && |(test_result.major_fail & mask);
  always_ff @(posedge aclk) begin
    if (!aresetn || test_done)
      busy_r <= 1'b0;
    else if (test_start)
      busy_r <= 1'b1;
  end
  // cycles with the watchdog idle, for the restart delay
  always_ff @(posedge aclk) begin
    if (!aresetn || watchdog_ok)
      fs_cnt_r <= 32'h0;
    else
      fs_cnt_r <= fs_cnt_r + 32'h1;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  relay_idle_a: assert property (!watchdog_ok |-> relay_drive == '0)
    else $error("relay drive active in fail-safe");
  protect_off_a: assert property (!watchdog_ok |-> !protection_enable)
    else $error("protection enabled in fail-safe");
  red_led_a: assert property ($fell(watchdog_ok) |->
    display.red_led && display.diag_code != 8'h0)
    else $error("no red indicator or code in fail-safe");
  major_enter_a: assert property (mj_fail |=>
    !watchdog_ok && relay_drive == '0)
    else $error("major failure did not enter fail-safe");
  minor_flag_a: assert property (test_done && busy_r && watchdog_ok &&
    |test_result.minor_fail |=> display.minor_flag)
    else $error("minor failure not flagged");
  relay_pass_a: assert property (watchdog_ok && $past(watchdog_ok) |->
    relay_drive == $past(relay_request))
    else $error("relay drive does not follow request");
  cyclic_start_a: assert property (test_done && busy_r &&
    watchdog_ok && !mj_fail |-> ##[1:CYC_MAX] test_start)
    else $error("cyclic self-test not started");
  restart_start_a: assert property ($fell(watchdog_ok) |->
    ##[HOLD_LO:HOLD_HI] test_start && test_init_phase)
    else $error("restart self-test not started in time");
  hold_min_a: assert property (test_start && !watchdog_ok |->
    fs_cnt_r >= 32'(HOLD_LO))
    else $error("restart before fail-safe hold ended");
  lockout_a: assert property (mj_fail && !watchdog_ok |=>
    (!watchdog_ok && !test_start) [*8])
    else $error("left fail-safe after failed restart");
endmodule

bind failure_supervisor failure_supervisor_properties #(
  .FS_HOLD(FS_HOLD),
  .CYCLE(CYCLE)
) chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .test_start(test_start),
  .test_init_phase(test_init_phase),
  .test_done(test_done),
  .test_result(test_result),
  .relay_request(relay_request),
  .relay_drive(relay_drive),
  .protection_enable(protection_enable),
  .watchdog_ok(watchdog_ok),
  .display(display)
);

// ==== verif/watchdog_monitor.sv ====
`timescale 1ns/1ps
module watchdog_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic watchdog_ok,
  output logic alarm
);
  logic armed_r;
  // armed only after health was seen, so power-up stays quiet
  always_ff @(posedge aclk) begin
    if (!aresetn)
      armed_r <= 1'b0;
    else if (watchdog_ok)
      armed_r <= 1'b1;
  end
  assign alarm = armed_r && !watchdog_ok;
endmodule

// ==== verif/failure_supervisor_failsafe_bench.sv ====
`timescale 1ns/1ps
module failure_supervisor_failsafe_bench;
  import supervisor_pkg::*;
  localparam int unsigned HOLD = 50;
  localparam int unsigned CYC = 20;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, test_start, test_init_phase;
  logic test_done, protection_enable, watchdog_ok, alarm;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [2:0] supv_in;
  logic [7:0] relay_request, relay_drive;
  logic [12:0] plan;
  test_result_t test_result;
  display_t display;
  int n_mismatch = 0;
  int total_checks = 0;
  failure_supervisor #(
    .FS_HOLD(HOLD),
    .CYCLE(CYC)
  ) uut (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid),
    .s_axi_awready(awready),
    .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid),
    .s_axi_wready(wready),
    .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid),
    .s_axi_bready(bready),
    .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid),
    .s_axi_arready(arready),
    .s_axi_rdata(rdata),
    .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid),
    .s_axi_rready(rready),
    .test_start(test_start),
    .test_init_phase(test_init_phase),
    .test_done(test_done),
    .test_result(test_result),
    .supv_alarm_in(supv_in),
    .relay_request(relay_request),
    .relay_drive(relay_drive),
    .protection_enable(protection_enable),
    .watchdog_ok(watchdog_ok),
    .display(display)
  );
  watchdog_monitor mon (
    .aclk(aclk),
    .aresetn(aresetn),
    .watchdog_ok(watchdog_ok),
    .alarm(alarm)
  );
  // ******
  // clock, self-test units, hang limit
  // ******
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // every pass answers one cycle later with the planned result
  initial begin
    test_done = 1'b0;
    test_result = '0;
    forever begin
      @(posedge aclk);
      test_done <= test_start;
      test_result <= plan;
    end
  end
  // tests need under 1000 cycles; the limit leaves a wide margin
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    finish_test();
  end
  // ******
  // shared tasks
  // ******
  task check_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task do_reset;
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  // waits for the answer however long it takes; the hang limit ends it
  task axi_write(input logic [3:0] a, input logic [31:0] d,
                 input logic [1:0] exp_resp);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    check_val(bresp, exp_resp);
    @(posedge aclk);
  endtask
  task axi_read(input logic [3:0] a, output logic [31:0] d,
                output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task read_chk(input logic [3:0] a, input logic [31:0] m,
                input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check_val(d & m, e);
  endtask
  // waits for the next pass, which reports result p
  task test_pass(input logic [12:0] p, input logic init);
    int n;
    plan <= p;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (test_start !== 1'b1 && n < 400);
    check_val(test_init_phase, init);
    @(posedge aclk);
    plan <= 13'h0;
    repeat (2) @(posedge aclk);
  endtask
  task quiet_chk;
    int bad;
    bad = 0;
    repeat (3 * HOLD) begin
      @(posedge aclk);
      if (test_start !== 1'b0 || watchdog_ok !== 1'b0)
        bad++;
    end
    check_val(bad, 0);
  endtask
  // ******
  // scenarios
  // ******
  task t_init;
    // the power-up pass starts on the first edge after release
    do_reset();
    test_pass({10'h001, 3'h0}, 1'b1);
    check_val(watchdog_ok, 1'b1);
    check_val(protection_enable, 1'b1);
    check_val(display.diag_code, 8'h00);
    check_val(relay_drive, 8'ha5);
    $display("test init done");
  endtask
  task t_minor;
    test_pass({10'h010, 3'h1}, 1'b0);
    check_val(watchdog_ok, 1'b1);
    check_val(display.minor_flag, 1'b1);
    relay_request <= 8'h3c;
    repeat (3) @(posedge aclk);
    check_val(relay_drive, 8'h3c);
    check_val(protection_enable, 1'b1);
    read_chk(ADDR_STATUS, 32'h80, 32'h80);
    test_pass({10'h000, 3'h6}, 1'b0);
    read_chk(ADDR_MINOR, 32'h7, 32'h7);
    $display("test minor done");
  endtask
  task t_supv;
    logic [31:0] d;
    logic [1:0] r;
    supv_in <= 3'h5;
    axi_write(ADDR_CTRL, 32'h3, RESP_OKAY);
    repeat (3) @(posedge aclk);
    check_val(display.supv_alarm, 3'h1);
    read_chk(ADDR_MINOR, 32'h38, 32'h8);
    read_chk(ADDR_CTRL, 32'h7, 32'h3);
    axi_write(ADDR_STATUS, 32'hffff_ffff, RESP_OKAY);
    read_chk(ADDR_STATUS, 32'h7ff, 32'h82);
    axi_write(4'h2, 32'h7, RESP_SLVERR);
    axi_read(4'h2, d, r);
    check_val(r, RESP_SLVERR);
    check_val(d, 32'h0);
    $display("test supervision done");
  endtask
  task t_transient;
    int idx [5] = '{1, 2, 3, 5, 6};
    for (int i = 0; i < 5; i++) begin
      test_pass({10'(1 << idx[i]), 3'h0}, 1'b0);
      check_val(watchdog_ok, 1'b0);
      check_val(alarm, 1'b1);
      check_val(protection_enable, 1'b0);
      check_val(relay_drive, 8'h0);
      check_val(display.red_led, 1'b1);
      check_val(display.diag_code, 8'(idx[i] + 1));
      test_pass(13'h0, 1'b1);
      check_val(watchdog_ok, i < 4);
      read_chk(ADDR_STATUS, 32'h700, 32'((i + 1) << 8));
    end
    quiet_chk();
    read_chk(ADDR_STATUS, 32'h740, 32'h540);
    $display("test transient done");
  endtask
  task t_perm;
    do_reset();
    test_pass({10'h010, 3'h0}, 1'b1);
    check_val(watchdog_ok, 1'b0);
    check_val(display.diag_code, 8'h5);
    read_chk(ADDR_STATUS, 32'h700, 32'h0);
    test_pass({10'h010, 3'h0}, 1'b1);
    quiet_chk();
    read_chk(ADDR_STATUS, 32'h40, 32'h40);
    $display("test permanent done");
  endtask
  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    supv_in = 3'h0;
    relay_request = 8'ha5;
    plan = 13'h0;
    t_init();
    t_minor();
    t_supv();
    t_transient();
    t_perm();
    finish_test();
  end
endmodule
